// ==== hdl/rcw_top.sv ====
// rtc counter with wrap limit and match value behind apb
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "rcw_params.svh"
module rcw_top #(
    parameter int AW = 12
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          pce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rtc_clk_pin,
    output logic               irq
);
    // register indices as word indices
    logic [7:0] idx;
    logic       aligned;
    logic       hit_ctrl;
    logic       hit_status;
    logic       hit_mask;
    logic       hit_flags;
    logic       hit_temp;
    logic       hit_cnt_lo;
    logic       hit_cnt_hi;
    logic       hit_wrap_lo;
    logic       hit_wrap_hi;
    logic       hit_match_lo;
    logic       hit_match_hi;
    logic       mapped;

    assign idx          = paddr[9:2];
    assign aligned      = (paddr[1:0] == 2'h0) && (paddr[AW-1:10] == '0);
    assign hit_ctrl     = aligned && (idx == `RCW_IDX_CTRL);
    assign hit_status   = aligned && (idx == `RCW_IDX_STATUS);
    assign hit_mask     = aligned && (idx == `RCW_IDX_INT_MASK);
    assign hit_flags    = aligned && (idx == `RCW_IDX_INT_FLAGS);
    assign hit_temp     = aligned && (idx == `RCW_IDX_TEMP);
    assign hit_cnt_lo   = aligned && (idx == `RCW_IDX_COUNT_LO);
    assign hit_cnt_hi   = aligned && (idx == `RCW_IDX_COUNT_HI);
    assign hit_wrap_lo  = aligned && (idx == `RCW_IDX_WRAP_LO);
    assign hit_wrap_hi  = aligned && (idx == `RCW_IDX_WRAP_HI);
    assign hit_match_lo = aligned && (idx == `RCW_IDX_MATCH_LO);
    assign hit_match_hi = aligned && (idx == `RCW_IDX_MATCH_HI);
    assign mapped       = hit_ctrl | hit_status | hit_mask | hit_flags | hit_temp
                        | hit_cnt_lo | hit_cnt_hi | hit_wrap_lo | hit_wrap_hi
                        | hit_match_lo | hit_match_hi;

    // apb phases
    logic setup_rd;
    logic access;
    logic wr_en;

    assign setup_rd = pce && psel && !penable && !pwrite;
    assign access   = psel && penable;
    assign wr_en    = pce && access && pwrite && mapped && pstrb[0];
    assign pready   = pce;
    assign pslverr  = access && !mapped;

    // software visible state
    rcw_pkg::rcw_byte_t ctrl;
    rcw_pkg::rcw_byte_t int_mask;
    logic [1:0]         int_flags;
    rcw_pkg::rcw_byte_t temp;
    rcw_pkg::rcw_word_t wrap_limit;
    rcw_pkg::rcw_word_t match_value;
    rcw_pkg::rcw_word_t counter_value;
    rcw_pkg::rcw_word_t high_word;

    assign high_word = {pwdata[7:0], temp};

    // rtc pin synchroniser and tick detect
    logic rtc_s1;
    logic rtc_s2;
    logic rtc_s3;
    logic rtc_level;
    logic rtc_tick;

    assign rtc_tick = (rtc_s2 == rtc_s3) && rtc_s3 && !rtc_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_s1    <= 1'b0;
            rtc_s2    <= 1'b0;
            rtc_s3    <= 1'b0;
            rtc_level <= 1'b0;
        end else if (pce) begin
            rtc_s1 <= rtc_clk_pin;
            rtc_s2 <= rtc_s1;
            rtc_s3 <= rtc_s2;
            if (rtc_s2 == rtc_s3) begin
                rtc_level <= rtc_s3;
            end
        end
    end

    // prescaler on rtc ticks
    logic [7:0] presc_cnt;
    logic [7:0] presc_mask;
    logic [2:0] presc_sel;
    logic       count_enable;
    logic       count_tick;

    assign presc_sel    = ctrl[`RCW_CTRL_PRESC_MSB:`RCW_CTRL_PRESC_LSB];
    assign presc_mask   = 8'((9'h001 << presc_sel) - 9'h001);
    assign count_enable = ctrl[`RCW_CTRL_ENABLE_BIT];
    assign count_tick   = count_enable && rtc_tick && ((presc_cnt & presc_mask) == presc_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt <= 8'h00;
        end else if (pce) begin
            if (!count_enable) begin
                presc_cnt <= 8'h00;
            end else if (rtc_tick) begin
                presc_cnt <= presc_cnt + 8'h01;
            end
        end
    end

    // crossing channels
    logic               cnt_load;
    logic               wrap_load;
    logic               match_load;
    logic               cnt_busy;
    logic               wrap_busy;
    logic               match_busy;
    logic               cnt_apply;
    rcw_pkg::rcw_word_t cnt_synced;
    rcw_pkg::rcw_word_t wrap_synced;
    rcw_pkg::rcw_word_t match_synced;

    assign cnt_load   = wr_en && hit_cnt_hi;
    assign wrap_load  = wr_en && hit_wrap_hi;
    assign match_load = wr_en && hit_match_hi;

    rcw_sync_chan #(
        .SYNC_TICKS  (`RCW_SYNC_TICKS),
        .RESET_VALUE (`RCW_COUNT_RESET)
    ) u_cnt_chan (
        .pclk       (pclk),
        .presetn    (presetn),
        .pce        (pce),
        .rtc_tick   (rtc_tick),
        .load       (cnt_load),
        .load_value (high_word),
        .busy       (cnt_busy),
        .apply      (cnt_apply),
        .value      (cnt_synced)
    );

    rcw_sync_chan #(
        .SYNC_TICKS  (`RCW_SYNC_TICKS),
        .RESET_VALUE (`RCW_WRAP_RESET)
    ) u_wrap_chan (
        .pclk       (pclk),
        .presetn    (presetn),
        .pce        (pce),
        .rtc_tick   (rtc_tick),
        .load       (wrap_load),
        .load_value (high_word),
        .busy       (wrap_busy),
        .apply      (),
        .value      (wrap_synced)
    );

    rcw_sync_chan #(
        .SYNC_TICKS  (`RCW_SYNC_TICKS),
        .RESET_VALUE (`RCW_MATCH_RESET)
    ) u_match_chan (
        .pclk       (pclk),
        .presetn    (presetn),
        .pce        (pce),
        .rtc_tick   (rtc_tick),
        .load       (match_load),
        .load_value (high_word),
        .busy       (match_busy),
        .apply      (),
        .value      (match_synced)
    );

    // counting
    logic               at_wrap;
    logic               overflow_event;
    logic               match_eq;
    logic               match_eq_q;
    logic               match_event;
    rcw_pkg::rcw_word_t next_counter_value;

    assign at_wrap        = (counter_value == wrap_synced);
    assign overflow_event = count_tick && !cnt_apply && at_wrap;
    assign match_eq       = (counter_value == match_synced);
    assign match_event    = match_eq && !match_eq_q;

    always_comb begin
        next_counter_value = counter_value;
        if (cnt_apply) begin
            next_counter_value = cnt_synced;
        end else if (count_tick) begin
            next_counter_value = at_wrap ? 16'h0000 : counter_value + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= `RCW_COUNT_RESET;
            match_eq_q    <= 1'b1;
        end else if (pce) begin
            counter_value <= next_counter_value;
            match_eq_q    <= match_eq;
        end
    end

    // flags, set wins over clear
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    assign flag_set = {match_event, overflow_event};
    assign flag_clr = (wr_en && hit_flags) ? pwdata[1:0] : 2'b00;
    assign irq      = |(int_flags & int_mask[1:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_flags <= 2'b00;
        end else if (pce) begin
            int_flags <= (int_flags & ~flag_clr) | flag_set;
        end
    end

    // plain registers and shadows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= `RCW_BYTE_RESET;
            int_mask    <= `RCW_BYTE_RESET;
            wrap_limit  <= `RCW_WRAP_RESET;
            match_value <= `RCW_MATCH_RESET;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl <= pwdata[7:0];
            end
            if (hit_mask) begin
                int_mask <= pwdata[7:0];
            end
            if (hit_wrap_hi) begin
                wrap_limit <= high_word;
            end
            if (hit_match_hi) begin
                match_value <= high_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp <= `RCW_BYTE_RESET;
        end else if (wr_en && (hit_temp || hit_cnt_lo || hit_wrap_lo || hit_match_lo)) begin
            temp <= pwdata[7:0];
        end else if (setup_rd && hit_cnt_lo) begin
            temp <= counter_value[15:8];
        end else if (setup_rd && hit_wrap_lo) begin
            temp <= wrap_limit[15:8];
        end else if (setup_rd && hit_match_lo) begin
            temp <= match_value[15:8];
        end
    end

    // read mux
    rcw_pkg::rcw_byte_t status_byte;
    rcw_pkg::rcw_byte_t rd_byte;

    assign status_byte = {4'h0, match_busy, wrap_busy, cnt_busy, 1'b0};
    assign rd_byte     = hit_ctrl     ? ctrl
                       : hit_status   ? status_byte
                       : hit_mask     ? int_mask
                       : hit_flags    ? {6'h00, int_flags}
                       : hit_temp     ? temp
                       : hit_cnt_lo   ? counter_value[7:0]
                       : hit_wrap_lo  ? wrap_limit[7:0]
                       : hit_match_lo ? match_value[7:0]
                       : (hit_cnt_hi || hit_wrap_hi || hit_match_hi) ? temp
                       : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end
endmodule

// ==== pkg/rcw_params.svh ====
// register map, field positions, reset values and sync counts
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

`define RCW_IDX_CTRL           8'h00
`define RCW_IDX_STATUS         8'h01
`define RCW_IDX_INT_MASK       8'h02
`define RCW_IDX_INT_FLAGS      8'h03
`define RCW_IDX_TEMP           8'h04
`define RCW_IDX_COUNT_LO       8'h08
`define RCW_IDX_COUNT_HI       8'h09
`define RCW_IDX_WRAP_LO        8'h0A
`define RCW_IDX_WRAP_HI        8'h0B
`define RCW_IDX_MATCH_LO       8'h0C
`define RCW_IDX_MATCH_HI       8'h0D

`define RCW_COUNT_RESET        16'h0000
`define RCW_WRAP_RESET         16'hFFFF
`define RCW_MATCH_RESET        16'h0000
`define RCW_BYTE_RESET         8'h00

`define RCW_CTRL_ENABLE_BIT    0
`define RCW_CTRL_PRESC_LSB     1
`define RCW_CTRL_PRESC_MSB     3
`define RCW_STAT_COUNT_BUSY    1
`define RCW_STAT_WRAP_BUSY     2
`define RCW_STAT_MATCH_BUSY    3
`define RCW_FLAG_OVERFLOW      0
`define RCW_FLAG_MATCH         1

`define RCW_SYNC_TICKS         2

`endif

// ==== pkg/rcw_pkg.sv ====
// shared types of the rtc count, wrap and match block
package rcw_pkg;
    typedef logic [15:0] rcw_word_t;
    typedef logic [7:0]  rcw_byte_t;
    typedef enum logic [1:0] {
        CHAN_IDLE = 2'b01,
        CHAN_WAIT = 2'b10
    } rcw_chan_state_t;
endpackage

// ==== hdl/rcw_sync_chan.sv ====
// one value crossing into the rtc tick domain
`timescale 1ns/1ps
module rcw_sync_chan #(
    parameter int                 SYNC_TICKS  = 2,
    parameter rcw_pkg::rcw_word_t RESET_VALUE = 16'h0000
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pce,
    input  wire logic               rtc_tick,
    input  wire logic               load,
    input  wire rcw_pkg::rcw_word_t load_value,
    output logic                    busy,
    output logic                    apply,
    output rcw_pkg::rcw_word_t      value
);
    localparam int CW = (SYNC_TICKS < 2) ? 1 : $clog2(SYNC_TICKS);

    rcw_pkg::rcw_chan_state_t state;
    rcw_pkg::rcw_word_t       hold;
    logic [CW-1:0]            tick_cnt;
    logic                     last_tick;

    assign last_tick = (tick_cnt == CW'(SYNC_TICKS - 1));
    assign busy      = (state == rcw_pkg::CHAN_WAIT) | apply;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= rcw_pkg::CHAN_IDLE;
            hold     <= 16'h0000;
            tick_cnt <= '0;
            value    <= RESET_VALUE;
            apply    <= 1'b0;
        end else if (pce) begin
            apply <= 1'b0;
            unique case (state)
                rcw_pkg::CHAN_IDLE: begin
                    if (load) begin
                        hold     <= load_value;
                        tick_cnt <= '0;
                        state    <= rcw_pkg::CHAN_WAIT;
                    end
                end
                rcw_pkg::CHAN_WAIT: begin
                    if (rtc_tick) begin
                        if (last_tick) begin
                            value <= hold;
                            apply <= 1'b1;
                            state <= rcw_pkg::CHAN_IDLE;
                        end else begin
                            tick_cnt <= tick_cnt + CW'(1);
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ==== verif/rcw_checker.sv ====
// bus and interrupt checks on the rtc count, wrap and match block
`timescale 1ns/1ps
module rcw_checker #(
    parameter int AW = 12
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          pce,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          rtc_clk_pin,
    input wire logic          irq
);
    wire       acc    = psel && penable && pce;
    wire [7:0] idx    = paddr[9:2];
    wire       in_map = (idx <= 8'h04) || (idx >= 8'h08 && idx <= 8'h0D);
    wire       mapped = (paddr[1:0] == 2'h0) && (paddr[AW-1:10] == '0) && in_map;
    wire       mask_0 = acc && pwrite && pstrb[0] && mapped && idx == 8'h02 && pwdata[1:0] == 2'h0;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_tracks_a: assert property (pready == pce) else $error("pready differs from pce");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    upper_zero_a: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
    unmapped_zero_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("data on unmapped");
    prdata_hold_a: assert property (!(psel && !penable && !pwrite && pce) |=> $stable(prdata))
        else $error("prdata changed without read");
    mask_quiet_a: assert property (mask_0 |=> !irq [*2]) else $error("irq with mask clear");
    status_spare_a: assert property (acc && !pwrite && mapped && idx == 8'h01 |-> prdata[7:4] == 4'h0)
        else $error("status spare bits set");
    flag_spare_a: assert property (acc && !pwrite && mapped && idx == 8'h03 |-> prdata[7:2] == 6'h00)
        else $error("flag spare bits set");
    cover property (acc && pwrite && mapped);
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule

bind rcw_top rcw_checker #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtc_clk_pin(rtc_clk_pin), .irq(irq));

// ==== verif/rcw_top_tb.sv ====
// register level test of the rtc count, wrap and match block
`timescale 1ns/1ps
`include "rcw_params.svh"
module rcw_top_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        pce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rtc_clk_pin = 1'b0;
    logic        irq;
    logic        rtc_run = 1'b0;
    logic [2:0]  rtc_div = 3'h0;
    logic [7:0]  q;
    logic        e;
    logic [15:0] w;
    int          err_total = 0;
    int          checks_done = 0;
    rcw_top #(.AW(12)) u_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rtc_clk_pin(rtc_clk_pin), .irq(irq));
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        rtc_div <= rtc_div + 3'h1;
        if (rtc_run && rtc_div == 3'h7) begin
            rtc_clk_pin <= ~rtc_clk_pin;
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic rd16(input logic [7:0] lo);
        apb(1'b0, lo, 8'h00);
        w[7:0] = q;
        apb(1'b0, lo + 8'h01, 8'h00);
        w[15:8] = q;
    endtask
    task automatic wait_bit(input int b, input logic [7:0] idx, input logic v);
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, idx, 8'h00);
            if (q[b] === v) begin
                break;
            end
        end
        check({31'h0, q[b]}, {31'h0, v});
        if (q[b] !== v) begin
            wrap_up();
        end
    endtask
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        apb(1'b1, lo, v[7:0]);
        apb(1'b1, lo + 8'h01, v[15:8]);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd16(`RCW_IDX_COUNT_LO);
        check({16'h0, w}, {16'h0, `RCW_COUNT_RESET});
        rd16(`RCW_IDX_WRAP_LO);
        check({16'h0, w}, {16'h0, `RCW_WRAP_RESET});
        rd16(`RCW_IDX_MATCH_LO);
        check({16'h0, w}, {16'h0, `RCW_MATCH_RESET});
        apb(1'b1, `RCW_IDX_COUNT_LO, 8'h34);
        apb(1'b0, `RCW_IDX_TEMP, 8'h00);
        check({24'h0, q}, 32'h34);
        apb(1'b1, `RCW_IDX_COUNT_HI, 8'h12);
        apb(1'b0, `RCW_IDX_STATUS, 8'h00);
        check({31'h0, q[`RCW_STAT_COUNT_BUSY]}, 32'h1);
        rd16(`RCW_IDX_COUNT_LO);
        check({16'h0, w}, 32'h0);
        rtc_run <= 1'b1;
        wait_bit(`RCW_STAT_COUNT_BUSY, `RCW_IDX_STATUS, 1'b0);
        rd16(`RCW_IDX_COUNT_LO);
        check({16'h0, w}, 32'h1234);
        wait_bit(`RCW_STAT_WRAP_BUSY, `RCW_IDX_STATUS, 1'b0);
        wr16(`RCW_IDX_WRAP_LO, 16'h0003);
        apb(1'b0, `RCW_IDX_STATUS, 8'h00);
        check({31'h0, q[`RCW_STAT_WRAP_BUSY]}, 32'h1);
        rd16(`RCW_IDX_WRAP_LO);
        check({16'h0, w}, 32'h0003);
        wr16(`RCW_IDX_MATCH_LO, 16'h0002);
        apb(1'b0, `RCW_IDX_STATUS, 8'h00);
        check({31'h0, q[`RCW_STAT_MATCH_BUSY]}, 32'h1);
        rd16(`RCW_IDX_MATCH_LO);
        check({16'h0, w}, 32'h0002);
        wr16(`RCW_IDX_COUNT_LO, 16'h0000);
        wait_bit(`RCW_STAT_COUNT_BUSY, `RCW_IDX_STATUS, 1'b0);
        apb(1'b1, `RCW_IDX_INT_MASK, 8'h03);
        apb(1'b1, `RCW_IDX_CTRL, 8'h01);
        wait_bit(`RCW_FLAG_OVERFLOW, `RCW_IDX_INT_FLAGS, 1'b1);
        wait_bit(`RCW_FLAG_MATCH, `RCW_IDX_INT_FLAGS, 1'b1);
        check({31'h0, irq}, 32'h1);
        rd16(`RCW_IDX_COUNT_LO);
        check({31'h0, w <= 16'h0003}, 32'h1);
        rtc_run <= 1'b0;
        apb(1'b1, `RCW_IDX_CTRL, 8'h00);
        apb(1'b1, `RCW_IDX_INT_MASK, 8'h00);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `RCW_IDX_INT_MASK, 8'h03);
        apb(1'b1, `RCW_IDX_INT_FLAGS, 8'h03);
        apb(1'b0, `RCW_IDX_INT_FLAGS, 8'h00);
        check({30'h0, q[1:0]}, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h05, 8'h00);
        check({23'h0, e, q}, 32'h100);
        apb(1'b1, 8'h0E, 8'h55);
        check({31'h0, e}, 32'h1);
        wrap_up();
    end
endmodule
